// [rtl/pin_state_pkg.sv]
// constants for the standby pin state control block
package pin_state_pkg;
  localparam int NUM_PINS = 8;
  localparam logic [7:0] ANALOG_PINS_RST = 8'h0F;
  localparam logic [7:0] IRQ_PINS_RST = 8'h05;
  localparam logic RELEASE_RST = 1'b0;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] OE_RST = 8'h00;
  localparam logic [7:0] PULLUP_RST = 8'h00;
  localparam logic [7:0] INPUT_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [7:0] ANALOG_SEL_RST = 8'h00;
  localparam logic [7:0] HIZ_OE = 8'h00;
  localparam logic [7:0] BLOCKED_IN = 8'h00;
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_SLEEP = 3'b010,
    MODE_HOLD  = 3'b100
  } pin_mode_e;
endpackage

// [rtl/standby_pin_state_control.sv]
// pin state control for normal, sleep, stop/watch and reset
// Function
// - stop/watch with release clear: hold last output, block input.
// - stop/watch with release set: output high impedance, pull-up kept, input blocked.
// - interrupt-capable pins pass input to interrupt detector when that request enabled.
// - in reset digital pins: output off, buffer on, input not used internally.
// - in reset analog-shared pins: output off, digital input gate blocked.
// - blocked input gate means core_in never sees pin level; outside reset, enabled interrupt-capable pins still reach the interrupt detector.
// - normal and sleep: pin is port or peripheral, analog on analog pins.
// - the release bit lives in standby control, software writable, covers all pins.
// - output-configured pins follow the same standby and reset behaviour.
`timescale 1ns/1ps
module standby_pin_state_control (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       stop_mode,
  input  wire logic       watch_mode,
  input  wire logic       sleep_mode,
  input  wire logic       standby_control_wr,
  input  wire logic       standby_pin_release_wdata,
  input  wire logic [7:0] periph_sel,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe,
  input  wire logic [7:0] periph_out,
  input  wire logic [7:0] periph_oe,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] irq_req_en,
  input  wire logic [7:0] pin_in,
  output logic      [7:0] pin_out,
  output logic      [7:0] pin_oe,
  output logic      [7:0] pin_pullup,
  output logic      [7:0] core_in,
  output logic      [7:0] irq_in,
  output logic      [7:0] analog_sel,
  output logic            standby_pin_release
);

  // stop and watch share one pin treatment, so they are merged up front
  logic                     standby;
  pin_state_pkg::pin_mode_e mode_r;
  pin_state_pkg::pin_mode_e mode_nxt;
  logic                     hold_now;
  wire  [7:0]               sel_out;
  wire  [7:0]               sel_oe;
  wire  [7:0]               irq_gate;
  genvar                    gi;

  assign standby  = stop_mode | watch_mode;
  // decided from this cycle's inputs so the pins react one clock after a mode change
  assign hold_now = (mode_nxt == pin_state_pkg::MODE_HOLD);

  // mode tracking; sleep behaves like run at the pins
  always_comb
  begin
    mode_nxt = pin_state_pkg::MODE_RUN;
    case (mode_r)
      pin_state_pkg::MODE_RUN,
      pin_state_pkg::MODE_SLEEP,
      pin_state_pkg::MODE_HOLD:
      begin
        if (standby)
          mode_nxt = pin_state_pkg::MODE_HOLD;
        else if (sleep_mode)
          mode_nxt = pin_state_pkg::MODE_SLEEP;
        else
          mode_nxt = pin_state_pkg::MODE_RUN;
      end
      default:
      begin
        mode_nxt = pin_state_pkg::MODE_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mode_r <= pin_state_pkg::MODE_RUN;
    else
      mode_r <= mode_nxt;
  end

  // one software bit governs every pin; it survives standby, cleared by reset or by a software write of 0
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      standby_pin_release <= pin_state_pkg::RELEASE_RST;
    else if (standby_control_wr)
      standby_pin_release <= standby_pin_release_wdata;
  end

  // per-pin choice between port and peripheral, and the interrupt side path
  generate
    for (gi = 0; gi < pin_state_pkg::NUM_PINS; gi = gi + 1)
    begin : g_pin
      assign sel_out[gi]  = periph_sel[gi] ? periph_out[gi] : port_out[gi];
      assign sel_oe[gi]   = periph_sel[gi] ? periph_oe[gi] : port_oe[gi];
      // only interrupt-capable pins with the request enabled bypass the input block
      assign irq_gate[gi] = pin_state_pkg::IRQ_PINS_RST[gi] & irq_req_en[gi] & pin_in[gi];
    end
  endgenerate

  // pad drive: output ports and peripherals get the same standby treatment
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pin_out <= pin_state_pkg::OUT_RST;
      pin_oe  <= pin_state_pkg::OE_RST;
    end
    else if (hold_now)
    begin
      // release clear: nothing is loaded, so the last drive stays on the pad
      if (standby_pin_release)
        pin_oe <= pin_state_pkg::HIZ_OE;
      else
        pin_oe <= pin_oe;
    end
    else
    begin
      pin_out <= sel_out;
      pin_oe  <= sel_oe;
    end
  end

  // pull-up stays programmable while released; frozen with the pad otherwise
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pin_pullup <= pin_state_pkg::PULLUP_RST;
    else if (hold_now && !standby_pin_release)
      pin_pullup <= pin_pullup;
    else
      pin_pullup <= pullup_en;
  end

  // digital input path; in reset the buffer may see the pin but nothing downstream does
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      core_in    <= pin_state_pkg::INPUT_RST;
      analog_sel <= pin_state_pkg::ANALOG_SEL_RST;
    end
    else if (hold_now)
    begin
      core_in <= pin_state_pkg::BLOCKED_IN;
    end
    else
    begin
      core_in    <= pin_in;
      analog_sel <= periph_sel & pin_state_pkg::ANALOG_PINS_RST;
    end
  end

  // interrupt detector feed runs in every mode except reset, which clears it, so a wake-up edge is not lost
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      irq_in <= pin_state_pkg::IRQ_RST;
    else
      irq_in <= irq_gate;
  end

  chk_hold_keeps_state: assert property (
    @(posedge mclk) disable iff (rst)
    standby && !standby_pin_release |=> $stable(pin_out) && $stable(pin_oe))
    else $error("hold with release clear changed a pin output");

  chk_release_hiz: assert property (
    @(posedge mclk) disable iff (rst)
    standby && standby_pin_release |=> pin_oe == pin_state_pkg::HIZ_OE)
    else $error("released pin still driven in standby");

  chk_release_pullup: assert property (
    @(posedge mclk) disable iff (rst)
    standby && standby_pin_release |=> pin_pullup == $past(pullup_en))
    else $error("pull-up setting ignored while released");

  chk_standby_input_block: assert property (
    @(posedge mclk) disable iff (rst)
    standby |=> core_in == pin_state_pkg::BLOCKED_IN)
    else $error("pin level reached core during standby");

  chk_irq_pass_through: assert property (
    @(posedge mclk) disable iff (rst)
    standby |=> irq_in == ($past(pin_in) & $past(irq_req_en) & pin_state_pkg::IRQ_PINS_RST))
    else $error("interrupt input not passed in standby");

  chk_run_follows_select: assert property (
    @(posedge mclk) disable iff (rst)
    !standby |=> pin_out == $past(sel_out) && pin_oe == $past(sel_oe) && core_in == $past(pin_in))
    else $error("run or sleep pin did not follow its function");

  chk_release_bit_write: assert property (
    @(posedge mclk) disable iff (rst)
    standby_control_wr |=> standby_pin_release == $past(standby_pin_release_wdata))
    else $error("release bit write lost");

  chk_reset_pin_state: assert property (
    @(posedge mclk)
    rst && $past(rst) |-> pin_oe == pin_state_pkg::OE_RST && core_in == pin_state_pkg::INPUT_RST)
    else $error("pin not released or input not idle in reset");

  chk_mode_one_hot: assert property (
    @(posedge mclk) disable iff (rst)
    $onehot(mode_r))
    else $error("mode state not one-hot");

  cov_hold_kept: cover property (
    @(posedge mclk) disable iff (rst) standby && !standby_pin_release);

  cov_hold_released: cover property (
    @(posedge mclk) disable iff (rst) standby && standby_pin_release);

  cov_irq_wake_path: cover property (
    @(posedge mclk) disable iff (rst) standby && (|irq_gate));

  cov_sleep_periph: cover property (
    @(posedge mclk) disable iff (rst) sleep_mode && (|periph_sel));
endmodule

// [testbench/board_model.sv]
// board side: drives pins back, pulls released pins to fixed levels
`timescale 1ns/1ps
module board_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  output logic      [7:0] pin_in
);
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & 8'h3C);
endmodule

// [testbench/test_standby_pin_state_control.sv]
// bench for standby pin state control
`timescale 1ns/1ps
module test_standby_pin_state_control;
  logic mclk='0, rst='1, stop_mode='0, watch_mode='0, sleep_mode='0, standby_control_wr='0;
  logic standby_pin_release_wdata='0, standby_pin_release;
  logic [7:0] periph_sel='0, port_out='0, port_oe='0, periph_out='0, periph_oe='0, pullup_en='0, irq_req_en='0;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, core_in, irq_in, analog_sel;
  int err_count=0, n_tests=0, cyc=0;
  standby_pin_state_control u_dut (.*);
  board_model u_brd (.pin_out, .pin_oe, .pin_in);
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc > 500)
    begin
      err_count++;
      test_done();
    end
  end
  task cmp(input logic [7:0] a, input logic [7:0] e);
    n_tests++;
    if (a !== e)
    begin
      err_count++;
      $display("Error %0t bad pin state %h expected %h", $time, a, e);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task test_done;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task t_reset_state;
    cmp(pin_oe, 8'h00);
    cmp(pin_out, 8'h00);
    cmp(core_in, 8'h00);
    cmp(irq_in, 8'h00);
    cmp({7'h00, standby_pin_release}, 8'h00);
  endtask
  task t_run;
    @(posedge mclk);
    rst <= 1'b0;
    port_oe <= 8'hFF;
    port_out <= 8'hA5;
    irq_req_en <= 8'hFF;
    step(2);
    cmp(pin_oe, 8'hFF);
    cmp(pin_out, 8'hA5);
    cmp(core_in, 8'hA5);
    cmp(irq_in, 8'h05);
    cmp(pin_pullup, 8'h00);
  endtask
  task t_sleep;
    @(posedge mclk);
    sleep_mode <= 1'b1;
    periph_sel <= 8'h0F;
    periph_out <= 8'h03;
    periph_oe <= 8'h0F;
    port_out <= 8'hF0;
    port_oe <= 8'hF0;
    step(2);
    cmp(pin_out, 8'hF3);
    cmp(pin_oe, 8'hFF);
    cmp(analog_sel, 8'h0F);
    cmp(core_in, 8'hF3);
  endtask
  task t_hold;
    @(posedge mclk);
    sleep_mode <= 1'b0;
    stop_mode <= 1'b1;
    port_out <= 8'h00;
    periph_sel <= 8'h00;
    step(2);
    cmp(pin_out, 8'hF3);
    cmp(pin_oe, 8'hFF);
    cmp(core_in, 8'h00);
    cmp(irq_in, 8'h01);
  endtask
  task t_irq;
    @(posedge mclk);
    irq_req_en <= 8'h00;
    step(2);
    cmp(irq_in, 8'h00);
  endtask
  task t_rel;
    @(posedge mclk);
    standby_control_wr <= 1'b1;
    standby_pin_release_wdata <= 1'b1;
    irq_req_en <= 8'hFF;
    pullup_en <= 8'h3C;
    step(2);
    cmp(pin_oe, 8'h00);
    cmp(pin_pullup, 8'h3C);
    cmp(core_in, 8'h00);
    cmp({7'h00, standby_pin_release}, 8'h01);
    step(1);
    cmp(irq_in, 8'h04);
  endtask
  task t_watch;
    @(posedge mclk);
    standby_control_wr <= 1'b0;
    stop_mode <= 1'b0;
    watch_mode <= 1'b1;
    step(2);
    cmp(pin_oe, 8'h00);
    cmp(core_in, 8'h00);
  endtask
  task t_exit;
    @(posedge mclk);
    watch_mode <= 1'b0;
    step(2);
    cmp(pin_out, 8'h00);
    cmp(pin_oe, 8'hF0);
    cmp(core_in, 8'h0C);
  endtask
  task t_mid_reset;
    @(posedge mclk);
    rst <= 1'b1;
    step(1);
    cmp(pin_oe, 8'h00);
    cmp(core_in, 8'h00);
    cmp(pin_pullup, 8'h00);
    cmp({7'h00, standby_pin_release}, 8'h00);
    step(3);
    rst <= 1'b0;
    step(2);
    cmp(pin_oe, 8'hF0);
    cmp(pin_out, 8'h00);
  endtask
  initial
  begin
    step(10);
    t_reset_state();
    t_run();
    t_sleep();
    t_hold();
    t_irq();
    t_rel();
    t_watch();
    t_exit();
    t_mid_reset();
    test_done();
  end
endmodule
